// [rtl/rss_defines.vh]
// Constants for the receiver strobe and serial I/O block.
// Assumes a 25 MHz system clock; included by rtl/rss_top.v and rtl/rss_fifo.v.
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

`define RSS_CLK_HZ 25000000
`define RSS_MARK_MIN_NS 150
// Least width rounds up: 150 ns at 40 ns is 4 cycles, must exceed 3.75
`define RSS_MARK_MIN_CYC ((`RSS_MARK_MIN_NS * 25 + 999) / 1000)
`define RSS_RST_MIN_US 20
// Reset shorter than this is a glitch; longest time rounds down
`define RSS_RST_MIN_CYC ((`RSS_RST_MIN_US * 25))
`define RSS_BAUD_DEFAULT 4'h2
`define RSS_BAUD_COUNT 9
`define RSS_FIFO_WIDTH 8
`define RSS_FIFO_DEPTH 16

`endif

// [rtl/rss_fifo.v]
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`include "rss_defines.vh"
module rss_fifo #(
    parameter WIDTH = `RSS_FIFO_WIDTH,
    parameter DEPTH = `RSS_FIFO_DEPTH,
    parameter AW = 4
) (
    input wire clk,
    input wire srst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0] wr_reg;
    reg [AW-1:0] rd_reg;
    reg [AW:0] cnt_reg;
    wire push;
    wire pop;

    assign in_ready = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always @(posedge clk) begin
        if (srst) begin
            wr_reg <= {AW{1'b0}};
            rd_reg <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_reg] <= in_data;
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : wr_reg + 1'b1;
            end
            if (pop)
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                          : rd_reg + 1'b1;
            if (push & ~pop)
                cnt_reg <= cnt_reg + 1'b1;
            else if (pop & ~push)
                cnt_reg <= cnt_reg - 1'b1;
        end
    end
endmodule // rss_fifo

// [rtl/rss_top.v]
// Strobe inputs/outputs and three serial ports of a navigation receiver.
// Assumes inputs synchronous to clk; firmware state arrives on plain ports.
`timescale 1ns/100ps
`include "rss_defines.vh"
module rss_top #(
    parameter RST_MIN_CYC = `RSS_RST_MIN_CYC,
    parameter MARK_MIN_CYC = `RSS_MARK_MIN_CYC,
    parameter DIV_W = 32
) (
    input wire clk,
    input wire srst,
    input wire ext_reset_n,
    input wire rx_error_state,
    input wire rx_position_valid,
    input wire sat_time_epoch,
    input wire mark_a_polarity,
    input wire mark_b_polarity,
    input wire mark_b_enable_cmd,
    input wire port_c_mode_none,
    input wire port_c_mode_set,
    input wire time_pulse_polarity,
    input wire [DIV_W-1:0] time_pulse_width,
    input wire freq_out_polarity,
    input wire [DIV_W-1:0] freq_half_period,
    input wire [3:0] baud_sel_a,
    input wire [3:0] baud_sel_b,
    input wire [3:0] baud_sel_c,
    input wire baud_load,
    input wire user_strap_pin,
    input wire mark_input_a,
    input wire mark_b_shared_pin,
    input wire serial_a_rx,
    input wire serial_a_cts,
    input wire serial_b_rx,
    input wire serial_b_cts,
    input wire [7:0] rx_data_byte,
    input wire rx_data_valid,
    output wire rx_data_ready,
    output wire [7:0] tx_data_byte,
    output wire tx_data_valid,
    input wire tx_data_ready,
    output reg error_flag_out,
    output reg position_valid_out,
    output reg time_pulse_out,
    output reg variable_freq_out,
    output reg mark_a_event,
    output reg mark_b_event,
    output reg serial_a_differential,
    output reg port_c_enabled,
    output reg [3:0] baud_a,
    output reg [3:0] baud_b,
    output reg [3:0] baud_c,
    output reg [15:0] baud_div_a,
    output reg [15:0] baud_div_b,
    output reg [15:0] baud_div_c,
    output wire serial_c_receive,
    output wire serial_a_rts,
    output wire serial_b_rts,
    output wire in_reset
);
    localparam ST_RESET = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [31:0] rst_cnt_reg;
    reg strap_taken_reg;
    reg [2:0] ma_sync_reg;
    reg [2:0] mb_sync_reg;
    reg [7:0] ma_cnt_reg;
    reg [7:0] mb_cnt_reg;
    reg ma_done_reg;
    reg mb_done_reg;
    reg [DIV_W-1:0] tp_cnt_reg;
    reg tp_active_reg;
    reg [DIV_W-1:0] vf_cnt_reg;
    reg vf_phase_reg;
    wire core_rst;
    wire ma_level;
    wire mb_level;

    // Bit rate divider for a 16x oversampling UART
    function [15:0] baud_div;
        input [3:0] sel;
        begin
            case (sel)
                4'h0: baud_div = 16'h028b; // 2400
                4'h1: baud_div = 16'h0146; // 4800
                4'h2: baud_div = 16'h00a3; // 9600
                4'h3: baud_div = 16'h0051; // 19200
                4'h4: baud_div = 16'h0029; // 38400
                4'h5: baud_div = 16'h001b; // 57600
                4'h6: baud_div = 16'h000e; // 115200
                4'h7: baud_div = 16'h0007; // 230400
                4'h8: baud_div = 16'h0003; // 460800
                default: baud_div = 16'h00a3;
            endcase
        end
    endfunction

    // Reset sequencer: one register releases every strobe together
    always @* begin
        case (state_reg)
            ST_RESET: state_next = ext_reset_n ? ST_RUN : ST_RESET;
            ST_RUN: state_next = ext_reset_n ? ST_RUN : ST_HOLD;
            ST_HOLD: begin
                if (ext_reset_n)
                    state_next = ST_RUN;
                else if (rst_cnt_reg >= RST_MIN_CYC - 1)
                    state_next = ST_RESET;
                else
                    state_next = ST_HOLD;
            end
            default: state_next = ST_RESET;
        endcase
    end

    always @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_RESET;
            rst_cnt_reg <= 32'h00000000;
        end else begin
            state_reg <= state_next;
            rst_cnt_reg <= (state_reg == ST_HOLD) ? rst_cnt_reg + 1'b1
                           : 32'h00000000;
        end
    end

    assign core_rst = srst | (state_reg == ST_RESET);
    assign in_reset = core_rst;

    // Strap caught once on the first clock after reset release
    always @(posedge clk) begin
        if (core_rst) begin
            strap_taken_reg <= 1'b0;
            serial_a_differential <= 1'b0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg <= 1'b1;
            serial_a_differential <= user_strap_pin;
        end
    end

    // Shared pin ownership and bit rates
    always @(posedge clk) begin
        if (core_rst) begin
            port_c_enabled <= 1'b1;
            baud_a <= `RSS_BAUD_DEFAULT;
            baud_b <= `RSS_BAUD_DEFAULT;
            baud_c <= `RSS_BAUD_DEFAULT;
        end else begin
            // Mark B only once the port has been put to no protocol
            if (port_c_mode_set)
                port_c_enabled <= ~port_c_mode_none;
            else if (mark_b_enable_cmd && !port_c_enabled)
                port_c_enabled <= 1'b0;
            if (baud_load) begin
                // Unknown codes are ignored, keeping the old rate
                if (baud_sel_a < `RSS_BAUD_COUNT)
                    baud_a <= baud_sel_a;
                if (baud_sel_b < `RSS_BAUD_COUNT)
                    baud_b <= baud_sel_b;
                if (baud_sel_c < `RSS_BAUD_COUNT)
                    baud_c <= baud_sel_c;
            end
        end
        baud_div_a <= baud_div(baud_a);
        baud_div_b <= baud_div(baud_b);
        baud_div_c <= baud_div(baud_c);
    end

    assign serial_c_receive = port_c_enabled ? mark_b_shared_pin : 1'b1;
    // RTS from FIFO ready on A and B only, CTS ignored; port C has no flow control
    assign serial_a_rts = ~rx_data_ready | serial_a_cts & 1'b0;
    assign serial_b_rts = ~rx_data_ready;

    // Mark inputs: three-stage sync, then a width qualifier
    always @(posedge clk) begin
        if (core_rst) begin
            ma_sync_reg <= 3'h7;
            mb_sync_reg <= 3'h7;
        end else begin
            ma_sync_reg <= {ma_sync_reg[1:0], mark_input_a};
            mb_sync_reg <= {mb_sync_reg[1:0], mark_b_shared_pin};
        end
    end

    // Polarity 0 means active low
    assign ma_level = ma_sync_reg[2] ^ ~mark_a_polarity;
    assign mb_level = (mb_sync_reg[2] ^ ~mark_b_polarity)
                      & ~port_c_enabled;

    always @(posedge clk) begin
        if (core_rst) begin
            ma_cnt_reg <= 8'h00;
            mb_cnt_reg <= 8'h00;
            ma_done_reg <= 1'b0;
            mb_done_reg <= 1'b0;
            mark_a_event <= 1'b0;
            mark_b_event <= 1'b0;
        end else begin
            mark_a_event <= 1'b0;
            mark_b_event <= 1'b0;
            if (!ma_level) begin
                ma_cnt_reg <= 8'h00;
                ma_done_reg <= 1'b0;
            end else if (!ma_done_reg) begin
                ma_cnt_reg <= ma_cnt_reg + 1'b1;
                if (ma_cnt_reg == MARK_MIN_CYC - 1) begin
                    mark_a_event <= 1'b1;
                    ma_done_reg <= 1'b1;
                end
            end
            if (!mb_level) begin
                mb_cnt_reg <= 8'h00;
                mb_done_reg <= 1'b0;
            end else if (!mb_done_reg) begin
                mb_cnt_reg <= mb_cnt_reg + 1'b1;
                if (mb_cnt_reg == MARK_MIN_CYC - 1) begin
                    mark_b_event <= 1'b1;
                    mb_done_reg <= 1'b1;
                end
            end
        end
    end

    // Flags and pulse outputs
    always @(posedge clk) begin
        if (core_rst) begin
            error_flag_out <= 1'b0;
            position_valid_out <= 1'b0;
            time_pulse_out <= 1'b1;
            tp_active_reg <= 1'b0;
            tp_cnt_reg <= {DIV_W{1'b0}};
            variable_freq_out <= 1'b1;
            vf_phase_reg <= 1'b0;
            vf_cnt_reg <= {DIV_W{1'b0}};
        end else begin
            error_flag_out <= rx_error_state;
            position_valid_out <= rx_position_valid;
            // Leading edge tracks the epoch strobe; width counts after it
            if (sat_time_epoch && time_pulse_width != {DIV_W{1'b0}}) begin
                tp_active_reg <= 1'b1;
                tp_cnt_reg <= time_pulse_width - 1'b1;
            end else if (tp_active_reg) begin
                if (tp_cnt_reg == {DIV_W{1'b0}})
                    tp_active_reg <= 1'b0;
                else
                    tp_cnt_reg <= tp_cnt_reg - 1'b1;
            end
            time_pulse_out <= (sat_time_epoch && time_pulse_width != 0
                               || tp_active_reg && tp_cnt_reg != 0)
                              ^ ~time_pulse_polarity;
            // Zero half period holds idle (0 Hz); fastest is clk/2
            if (freq_half_period == {DIV_W{1'b0}}) begin
                vf_phase_reg <= 1'b0;
                vf_cnt_reg <= {DIV_W{1'b0}};
            end else if (vf_cnt_reg >= freq_half_period - 1'b1) begin
                vf_cnt_reg <= {DIV_W{1'b0}};
                vf_phase_reg <= ~vf_phase_reg;
            end else begin
                vf_cnt_reg <= vf_cnt_reg + 1'b1;
            end
            variable_freq_out <= vf_phase_reg ^ ~freq_out_polarity;
        end
    end

    // Received bytes buffered toward the host link
    rss_fifo #(
        .WIDTH(`RSS_FIFO_WIDTH),
        .DEPTH(`RSS_FIFO_DEPTH),
        .AW(4)
    ) u_fifo (
        .clk(clk),
        .srst(core_rst),
        .in_valid(rx_data_valid),
        .in_ready(rx_data_ready),
        .in_data(rx_data_byte),
        .out_valid(tx_data_valid),
        .out_ready(tx_data_ready),
        .out_data(tx_data_byte)
    );
endmodule // rss_top

// [bench/rss_top_assertions.sv]
// Checker on the top ports of the strobe block.
// Assumes one clock; bound into rss_top below.
`timescale 1ns/100ps
module rss_top_assertions #(
    parameter DIV_W = 32
) (
    input wire clk,
    input wire srst,
    input wire in_reset,
    input wire rx_error_state,
    input wire rx_position_valid,
    input wire error_flag_out,
    input wire position_valid_out,
    input wire port_c_enabled,
    input wire mark_b_shared_pin,
    input wire serial_c_receive,
    input wire mark_a_event,
    input wire mark_b_event,
    input wire mark_input_a,
    input wire mark_a_polarity,
    input wire [3:0] baud_a,
    input wire time_pulse_out,
    input wire variable_freq_out,
    input wire sat_time_epoch,
    input wire time_pulse_polarity,
    input wire [DIV_W-1:0] time_pulse_width,
    input wire serial_a_rts,
    input wire rx_data_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    err_follow_a: assert property (
        !in_reset && !$past(in_reset) |->
        error_flag_out == $past(rx_error_state))
        else $error("error flag does not follow state");
    pv_follow_a: assert property (
        !in_reset && !$past(in_reset) |->
        position_valid_out == $past(rx_position_valid))
        else $error("position valid does not follow state");
    pin_mux_a: assert property (
        serial_c_receive == (port_c_enabled ? mark_b_shared_pin : 1'b1))
        else $error("shared pin routed wrongly");
    mark_b_off_a: assert property (
        port_c_enabled [*8] |-> !mark_b_event)
        else $error("mark b event while port c enabled");
    mark_a_cause_a: assert property (
        mark_a_event |-> $past(mark_input_a, 5) == $past(mark_a_polarity, 5))
        else $error("mark a event without active level");
    reset_dflt_a: assert property (
        in_reset && $past(in_reset) |-> port_c_enabled && baud_a == 4'h2
        && time_pulse_out && variable_freq_out)
        else $error("reset defaults wrong");
    pulse_lead_a: assert property (
        !in_reset && sat_time_epoch && !time_pulse_polarity
        && time_pulse_width != 0 |-> ##[1:2] !time_pulse_out)
        else $error("time pulse missing after epoch");
    rts_flow_a: assert property (
        serial_a_rts == !rx_data_ready)
        else $error("request to send wrong");
endmodule // rss_top_assertions

bind rss_top rss_top_assertions #(.DIV_W(DIV_W)) chk_i (.clk(clk),
    .srst(srst), .in_reset(in_reset), .rx_error_state(rx_error_state),
    .rx_position_valid(rx_position_valid),
    .error_flag_out(error_flag_out),
    .position_valid_out(position_valid_out),
    .port_c_enabled(port_c_enabled), .mark_b_shared_pin(mark_b_shared_pin),
    .serial_c_receive(serial_c_receive), .mark_a_event(mark_a_event),
    .mark_b_event(mark_b_event), .mark_input_a(mark_input_a),
    .mark_a_polarity(mark_a_polarity), .baud_a(baud_a),
    .time_pulse_out(time_pulse_out), .variable_freq_out(variable_freq_out),
    .sat_time_epoch(sat_time_epoch),
    .time_pulse_polarity(time_pulse_polarity),
    .time_pulse_width(time_pulse_width), .serial_a_rts(serial_a_rts),
    .rx_data_ready(rx_data_ready));

// [bench/rss_host_model.sv]
// Host side: external reset, shared pin and port C mode commands.
// Assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/100ps
module rss_host_model (
    input wire clk,
    output reg ext_reset_n,
    output reg mark_b_shared_pin,
    output reg port_c_mode_none,
    output reg port_c_mode_set,
    output reg mark_b_enable_cmd
);
    initial begin
        ext_reset_n = 1'b0; // Low from power-up
        mark_b_shared_pin = 1'b1; // Pulled up when idle
        port_c_mode_none = 1'b0;
        port_c_mode_set = 1'b0;
        mark_b_enable_cmd = 1'b0;
    end
    task hold_reset(input integer n);
        begin
            @(negedge clk) ext_reset_n = 1'b0;
            repeat (n) @(negedge clk); // Beyond the minimum
            ext_reset_n = 1'b1;
        end
    endtask
    // Mode none first, mark enable only after
    task free_mark_b;
        begin
            @(negedge clk) port_c_mode_none = 1'b1;
            port_c_mode_set = 1'b1;
            @(negedge clk) port_c_mode_set = 1'b0;
            mark_b_enable_cmd = 1'b1;
            @(negedge clk) mark_b_enable_cmd = 1'b0;
        end
    endtask
    task pulse_b(input integer n);
        begin
            @(negedge clk) mark_b_shared_pin = 1'b0;
            repeat (n) @(negedge clk);
            mark_b_shared_pin = 1'b1;
        end
    endtask
endmodule // rss_host_model

// [bench/rss_top_bench.sv]
// Self-checking bench for rss_top with the host model.
// Assumes a 25 MHz clock; short external reset parameter.
`timescale 1ns/100ps
module rss_top_bench;
    localparam RST_CYC = 4;
    logic clk, srst, err_s, pv_s, epoch, pol_a, tp_pol, vf_pol;
    logic load, strap, mark_a, rx_v, tx_r, pol_b, cts;
    logic [31:0] tp_w, vf_h;
    logic [3:0] sel;
    logic [7:0] rx_b;
    wire ext_n, pin_b, m_none, m_set, b_en, rdy, txv, erf, pvo, tpo, vfo;
    wire ea, eb, diff, pce, rcv_c, rts_a, rts_b, inr;
    wire [7:0] tx_b;
    wire [3:0] ba, bb, bc;
    wire [15:0] bd_a, bd_b, bd_c;
    integer n_errors = 0, n_checks = 0, cyc = 0, na = 0, nb = 0, i, k;
    rss_host_model host (.clk(clk), .ext_reset_n(ext_n),
        .mark_b_shared_pin(pin_b), .port_c_mode_none(m_none),
        .port_c_mode_set(m_set), .mark_b_enable_cmd(b_en));
    rss_top #(.RST_MIN_CYC(RST_CYC)) dut (.clk(clk), .srst(srst),
        .ext_reset_n(ext_n), .rx_error_state(err_s),
        .rx_position_valid(pv_s), .sat_time_epoch(epoch),
        .mark_a_polarity(pol_a), .mark_b_polarity(pol_b),
        .mark_b_enable_cmd(b_en), .port_c_mode_none(m_none),
        .port_c_mode_set(m_set), .time_pulse_polarity(tp_pol),
        .time_pulse_width(tp_w), .freq_out_polarity(vf_pol),
        .freq_half_period(vf_h), .baud_sel_a(sel), .baud_sel_b(sel),
        .baud_sel_c(sel), .baud_load(load), .user_strap_pin(strap),
        .mark_input_a(mark_a), .mark_b_shared_pin(pin_b),
        .serial_a_rx(1'b1), .serial_a_cts(cts), .serial_b_rx(1'b1),
        .serial_b_cts(cts), .rx_data_byte(rx_b), .rx_data_valid(rx_v),
        .rx_data_ready(rdy), .tx_data_byte(tx_b), .tx_data_valid(txv),
        .tx_data_ready(tx_r), .error_flag_out(erf),
        .position_valid_out(pvo), .time_pulse_out(tpo),
        .variable_freq_out(vfo), .mark_a_event(ea), .mark_b_event(eb),
        .serial_a_differential(diff), .port_c_enabled(pce), .baud_a(ba),
        .baud_b(bb), .baud_c(bc), .baud_div_a(bd_a), .baud_div_b(bd_b),
        .baud_div_c(bd_c), .serial_c_receive(rcv_c), .serial_a_rts(rts_a),
        .serial_b_rts(rts_b), .in_reset(inr));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task test_done;
        begin
            $display("checks %0d errors %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // A hang counts as one mismatch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ea === 1'b1) na <= na + 1;
        if (eb === 1'b1) nb <= nb + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task t_defaults;
        begin
            chk(pce, 1'b1);
            chk({ba, bb, bc}, 12'h222);
            chk({erf, pvo, tpo, vfo}, 4'h3);
            chk(diff, 1'b1);
        end
    endtask
    task t_flags;
        begin
            err_s = 1'b1;
            pv_s = 1'b1;
            repeat (2) @(negedge clk);
            chk({erf, pvo}, 2'h3);
            err_s = 1'b0;
            pv_s = 1'b0;
            repeat (2) @(negedge clk);
            chk({erf, pvo}, 2'h0);
        end
    endtask
    task pa(input integer n);
        begin
            @(negedge clk) mark_a = ~mark_a;
            repeat (n) @(negedge clk);
            mark_a = ~mark_a;
            repeat (12) @(negedge clk);
        end
    endtask
    task t_mark_a;
        begin
            k = na;
            pa(3);
            chk(na - k, 0);
            pa(6);
            chk(na - k, 1);
            pol_a = 1'b1;
            mark_a = 1'b0;
            pa(6);
            chk(na - k, 2);
        end
    endtask
    task t_mark_b;
        begin
            k = nb;
            host.pulse_b(6);
            repeat (12) @(negedge clk);
            chk(nb - k, 0);
            host.free_mark_b;
            chk(pce, 1'b0);
            host.pulse_b(6);
            repeat (12) @(negedge clk);
            chk(nb - k, 1);
            // Active high on an idle-high pin reads as one long mark
            pol_b = 1'b1;
            repeat (12) @(negedge clk);
            chk(nb - k, 2);
            pol_b = 1'b0;
        end
    endtask
    task t_pulse;
        begin
            @(negedge clk) epoch = 1'b1;
            k = 0;
            repeat (12) begin
                @(negedge clk) epoch = 1'b0;
                if (tpo === 1'b0) k = k + 1;
            end
            chk(k, 3);
        end
    endtask
    task t_freq;
        begin
            vf_h = 32'h2;
            repeat (6) @(negedge clk);
            k = 0;
            repeat (20) begin
                i = vfo;
                @(negedge clk);
                if (vfo !== i[0]) k = k + 1;
            end
            chk(k, 10);
            vf_h = 32'h0;
            repeat (6) @(negedge clk);
            chk(vfo, 1'b1);
        end
    endtask
    task t_baud;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                @(negedge clk) sel = i[3:0];
                load = 1'b1;
                @(negedge clk) load = 1'b0;
                chk({ba, bb, bc}, {3{i < 9 ? i[3:0] : 4'h8}});
            end
            // Divider lags the code by one clock; 16x oversampling
            @(negedge clk);
            chk(bd_a, 25000000 / (16 * 460800));
            chk(bd_b, 25000000 / (16 * 460800));
            chk(bd_c, 25000000 / (16 * 460800));
        end
    endtask
    task t_fifo;
        begin
            @(negedge clk) rx_v = 1'b1;
            cts = 1'b1;
            for (k = 0; k < 20 && rdy === 1'b1; k = k + 1) begin
                rx_b = k[7:0];
                @(negedge clk);
            end
            rx_v = 1'b0;
            chk(k, 16);
            chk({rts_a, rts_b}, 2'h3);
            tx_r = 1'b1;
            for (i = 0; i < 16; i = i + 1) begin
                chk({txv, tx_b}, {1'b1, i[7:0]});
                @(negedge clk);
            end
            chk(txv, 1'b0);
            tx_r = 1'b0;
        end
    endtask
    task t_ext_reset;
        begin
            host.hold_reset(RST_CYC + 2);
            chk({pce, ba}, 5'h12);
            repeat (2) @(negedge clk);
            chk({inr, tpo, vfo}, 3'h3);
        end
    endtask
    initial begin
        {srst, err_s, pv_s, epoch, pol_a, tp_pol, vf_pol} = 7'h40;
        {load, strap, mark_a, rx_v, tx_r} = 5'h0c;
        {pol_b, cts} = 2'h0;
        tp_w = 32'h3;
        vf_h = 32'h0;
        sel = 4'h2;
        rx_b = 8'h00;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        host.hold_reset(RST_CYC + 2);
        repeat (3) @(negedge clk);
        t_defaults;
        t_flags;
        t_mark_a;
        t_mark_b;
        t_pulse;
        t_freq;
        t_baud;
        t_fifo;
        t_ext_reset;
        test_done;
    end
endmodule // rss_top_bench
